// >>> sdc_consts.svh
// Constants for the serial D/A channel control block.
// Assumes inclusion by bare name from the package only; the design module uses its macros without including it.
`ifndef SDC_CONSTS_SVH
`define SDC_CONSTS_SVH
`define SDC_WORD_W 12
`define SDC_NCH 8
`define SDC_CODE_W 8
`define SDC_CH_MSB 11
`define SDC_CH_LSB 8
`define SDC_CMD_PD 4'h0
`define SDC_CMD_DA_LAST 4'h8
`define SDC_CMD_PD_REL 4'h9
`define SDC_CMD_SEL 4'hc
`define SDC_CMD_S2P 4'hd
`define SDC_CMD_P2S 4'he
`define SDC_CMD_DIR 4'hf
`define SDC_CODE_RST 8'h00
`define SDC_MASK_RST 8'h00
`define SDC_SHIFT_RST 12'h000
`endif

// >>> sdc_pkg.sv
// Types for the serial D/A channel control block.
// Assumes sdc_consts.svh is on the include path.
package sdc_pkg;
  `include "sdc_consts.svh"
  typedef struct packed {
    logic [3:0] chan;
    logic [7:0] data;
  } sdc_cmd_t;
  typedef struct packed {
    logic [7:0] da_sel;
    logic [7:0] dir_out;
    logic [7:0] port_val;
    logic powered_down;
  } sdc_state_t;
endpackage

// >>> sdc_ctrl.sv
// Control logic of an eight-channel 8-bit D/A with general I/O pins.
// Assumes serial link pins are asynchronous and sampled by clk_i; analog
// levels are presented as 8-bit codes per channel for an external ladder.
`timescale 1ns/100ps
module sdc_ctrl
  import sdc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic external_reset_n_i,
  input wire logic chip_select_low_i,
  input wire logic serial_clk_i,
  input wire logic serial_data_in_i,
  input wire logic [7:0] channel_pins_i,
  output logic serial_data_out_o,
  output logic [7:0] channel_pins_o,
  output logic [7:0] channel_pins_oe_b_o,
  output logic [7:0] da_enable_o,
  output logic [63:0] da_code_o,
  output logic analog_bias_en_o
);
  logic [2:0] cs_sync_r, sck_sync_r, sdi_sync_r, rstp_sync_r;
  logic [11:0] shift_r;
  logic [11:0] so_shift_r;
  logic [7:0] code_r [8];
  sdc_state_t st_r;
  logic p2s_armed_r, p2s_load_r;
  logic sdo_r;
  logic [7:0] pins_o_r, oe_b_r, da_en_r;
  logic [63:0] code_flat_r;
  logic bias_r;

  // Two flops per pin; third stage is only used for edge finding
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cs_sync_r <= 3'h7;
      sck_sync_r <= 3'h0;
      sdi_sync_r <= 3'h0;
      rstp_sync_r <= 3'h7;
    end else begin
      cs_sync_r <= {cs_sync_r[1:0], chip_select_low_i};
      sck_sync_r <= {sck_sync_r[1:0], serial_clk_i};
      sdi_sync_r <= {sdi_sync_r[1:0], serial_data_in_i};
      rstp_sync_r <= {rstp_sync_r[1:0], external_reset_n_i};
    end
  end

  wire cs_low = !cs_sync_r[1];
  wire cs_rise = cs_sync_r[1] && !cs_sync_r[2];
  wire cs_fall = !cs_sync_r[1] && cs_sync_r[2];
  wire sck_rise = sck_sync_r[1] && !sck_sync_r[2];
  wire sck_fall = !sck_sync_r[1] && sck_sync_r[2];
  wire ext_rst = !rstp_sync_r[1];
  wire shift_en = sck_rise && cs_low;
  wire [11:0] shift_nxt = {shift_r[10:0], sdi_sync_r[1]};
  sdc_cmd_t cmd;
  assign cmd = shift_r;
  wire is_da = (cmd.chan != `SDC_CMD_PD) && (cmd.chan <= `SDC_CMD_DA_LAST);
  wire [2:0] da_idx = 3'(cmd.chan - 4'h1);
  wire do_pd = cs_rise && (cmd.chan == `SDC_CMD_PD);
  wire do_rel = cs_rise && (cmd.chan == `SDC_CMD_PD_REL);
  wire do_sel = cs_rise && (cmd.chan == `SDC_CMD_SEL);
  wire do_dir = cs_rise && (cmd.chan == `SDC_CMD_DIR);
  wire do_s2p = cs_rise && (cmd.chan == `SDC_CMD_S2P);
  wire do_p2s = cs_rise && (cmd.chan == `SDC_CMD_P2S);
  // Data bit 0 maps to first channel
  // D0 is the last bit shifted and the code LSB
  wire [7:0] cmd_data = cmd.data;

  // Shift register is not cleared by select going high
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      shift_r <= `SDC_SHIFT_RST;
    end else if (ext_rst) begin
      shift_r <= `SDC_SHIFT_RST;
    end else if (shift_en) begin
      shift_r <= shift_nxt;
    end
  end

  generate
    for (genvar g = 0; g < `SDC_NCH; g++) begin : g_code
      always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          code_r[g] <= `SDC_CODE_RST;
        end else if (ext_rst) begin
          code_r[g] <= `SDC_CODE_RST;
        end else if (cs_rise && is_da && da_idx == 3'(g)) begin
          code_r[g] <= cmd_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= '{da_sel: `SDC_MASK_RST, dir_out: `SDC_MASK_RST,
                port_val: `SDC_MASK_RST, powered_down: 1'b1};
    end else if (ext_rst) begin
      st_r <= '{da_sel: `SDC_MASK_RST, dir_out: `SDC_MASK_RST,
                port_val: `SDC_MASK_RST, powered_down: 1'b1};
    end else begin
      if (do_pd) begin
        st_r.powered_down <= 1'b1;
        st_r.da_sel <= `SDC_MASK_RST;
      end else if (do_sel) begin
        st_r.da_sel <= cmd_data;
      end
      if (do_rel) begin
        st_r.powered_down <= 1'b0;
      end
      if (do_dir) begin
        st_r.dir_out <= cmd_data;
      end
      if (do_s2p) begin
        st_r.port_val <= cmd_data;
      end
    end
  end

  // Parallel capture on the first select fall after the command
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      p2s_armed_r <= 1'b0;
      p2s_load_r <= 1'b0;
      so_shift_r <= `SDC_SHIFT_RST;
      sdo_r <= 1'b0;
    end else if (ext_rst) begin
      p2s_armed_r <= 1'b0;
      p2s_load_r <= 1'b0;
      so_shift_r <= `SDC_SHIFT_RST;
      sdo_r <= 1'b0;
    end else begin
      if (do_p2s) begin
        p2s_armed_r <= 1'b1;
      end else if (cs_fall) begin
        p2s_armed_r <= 1'b0;
      end
      if (cs_fall && p2s_armed_r) begin
        so_shift_r <= {4'h0, {<<{channel_pins_i}}};
        p2s_load_r <= 1'b1;
      end else if (cs_fall) begin
        // Echo of previous word; undefined to the host
        so_shift_r <= shift_r;
        p2s_load_r <= 1'b0;
      end else if (sck_fall && cs_low) begin
        so_shift_r <= {so_shift_r[10:0], 1'b0};
      end
      sdo_r <= so_shift_r[11];
    end
  end

  // Pins in D/A mode are driven by the analog ladder, not the port
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pins_o_r <= `SDC_MASK_RST;
      oe_b_r <= 8'hff;
      da_en_r <= `SDC_MASK_RST;
      code_flat_r <= 64'h0;
      bias_r <= 1'b0;
    end else begin
      pins_o_r <= st_r.port_val;
      oe_b_r <= ~(st_r.dir_out & ~st_r.da_sel);
      da_en_r <= st_r.da_sel & {8{!st_r.powered_down}};
      code_flat_r <= {code_r[7], code_r[6], code_r[5], code_r[4],
                      code_r[3], code_r[2], code_r[1], code_r[0]};
      bias_r <= !st_r.powered_down;
    end
  end

  assign serial_data_out_o = sdo_r;
  assign channel_pins_o = pins_o_r;
  assign channel_pins_oe_b_o = oe_b_r;
  assign da_enable_o = da_en_r;
  assign da_code_o = code_flat_r;
  assign analog_bias_en_o = bias_r;

  property p_pd_cuts;
    @(posedge clk_i) disable iff (!rst_b_i)
      do_pd && !ext_rst |=> ##1 !bias_r && da_en_r == 8'h00;
  endproperty
  a_pd_cuts: assert property (p_pd_cuts) else $error("power-down not applied");

  logic [2:0] da_idx_q;
  always_ff @(posedge clk_i) da_idx_q <= da_idx;
  property p_da_update;
    @(posedge clk_i) disable iff (!rst_b_i)
      cs_rise && is_da && !ext_rst |=> code_r[da_idx_q] == $past(cmd_data);
  endproperty
  a_da_update: assert property (p_da_update) else $error("code not updated");

  property p_shift_hold;
    @(posedge clk_i) disable iff (!rst_b_i)
      !shift_en && !ext_rst |=> $stable(shift_r);
  endproperty
  a_shift_hold: assert property (p_shift_hold) else $error("shift register changed");

  property p_shift_in;
    @(posedge clk_i) disable iff (!rst_b_i)
      shift_en && !ext_rst |=> shift_r[0] == $past(sdi_sync_r[1]);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("bit not sampled");

  property p_reset_state;
    @(posedge clk_i) disable iff (!rst_b_i)
      ext_rst |=> ##1 oe_b_r == 8'hff && !bias_r && da_en_r == 8'h00;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

  property p_sel;
    @(posedge clk_i) disable iff (!rst_b_i)
      do_sel && !ext_rst |=> st_r.da_sel == $past(cmd_data);
  endproperty
  a_sel: assert property (p_sel) else $error("select not applied");

  property p_pd_dir_kept;
    @(posedge clk_i) disable iff (!rst_b_i)
      do_pd && !ext_rst |=> st_r.da_sel == 8'h00 && $stable(st_r.dir_out);
  endproperty
  a_pd_dir_kept: assert property (p_pd_dir_kept) else $error("direction lost");

  property p_no_exec;
    @(posedge clk_i) disable iff (!rst_b_i)
      !cs_rise && !ext_rst |=> $stable(st_r.da_sel);
  endproperty
  a_no_exec: assert property (p_no_exec) else $error("mode changed off select rise");
endmodule

// >>> sdc_host_model.sv
// Host side of the three-wire command link.
// Inserts its own 4-clock select-high gap before each frame; drives at clk_i fall.
`timescale 1ns/100ps
module sdc_host_model (
  input wire logic clk_i,
  output logic chip_select_low_o,
  output logic serial_clk_o,
  output logic serial_data_o
);
  // Serial clock rests low between frames
  initial begin
    chip_select_low_o = 1'b1;
    serial_clk_o = 1'b0;
    serial_data_o = 1'b0;
  end
  // Sends the top n bits of w, MSB first; n below 12 cuts a frame short
  task automatic send(input logic [11:0] w, input int n);
    repeat (4) @(negedge clk_i);
    chip_select_low_o = 1'b0;
    for (int i = 11; i > 11 - n; i--) begin
      repeat (2) @(negedge clk_i);
      serial_data_o = w[i];
      repeat (2) @(negedge clk_i);
      serial_clk_o = 1'b1;
      repeat (4) @(negedge clk_i);
      serial_clk_o = 1'b0;
    end
    repeat (2) @(negedge clk_i);
    chip_select_low_o = 1'b1;
    // Released line must not keep showing the last bit
    serial_data_o = ~serial_data_o;
  endtask
endmodule

// >>> test_serial_dac_channel_control.sv
// Self-checking bench for the serial D/A channel control block.
// Assumes sdc_pkg and sdc_host_model are compiled first.
`timescale 1ns/100ps
`define SDC_CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin failures++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end
module test_serial_dac_channel_control;
  import sdc_pkg::*;
  logic clk_i, rst_b_i, ext_rst_n, chip_select_low, sck, sdi, sdo, bias;
  logic [7:0] pins_in, pins_out, oe_b, da_en;
  logic [63:0] codes;
  int failures = 0;
  int tests_run = 0;
  sdc_ctrl u_sdc_ctrl (.clk_i(clk_i), .rst_b_i(rst_b_i), .external_reset_n_i(ext_rst_n),
    .chip_select_low_i(chip_select_low), .serial_clk_i(sck), .serial_data_in_i(sdi),
    .channel_pins_i(pins_in), .serial_data_out_o(sdo), .channel_pins_o(pins_out),
    .channel_pins_oe_b_o(oe_b), .da_enable_o(da_en), .da_code_o(codes),
    .analog_bias_en_o(bias));
  sdc_host_model u_sdc_host_model (.clk_i(clk_i), .chip_select_low_o(chip_select_low),
    .serial_clk_o(sck), .serial_data_o(sdi));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Execution plus output latency is about 4 clk; 10 leaves margin
  task automatic cmd(input logic [3:0] ch, input logic [7:0] d);
    u_sdc_host_model.send({ch, d}, 12);
    repeat (10) @(negedge clk_i);
  endtask
  task automatic chk_idle;
    `SDC_CHK("oe_b", 8'hff, oe_b)
    `SDC_CHK("da_en", 8'h00, da_en)
    `SDC_CHK("bias", 1'b0, bias)
  endtask
  task automatic t_setup;
    cmd(4'h9, 8'h00);
    `SDC_CHK("bias on", 1'b1, bias)
    cmd(4'hc, 8'h81);
    cmd(4'hf, 8'hff);
    `SDC_CHK("da_en sel", 8'h81, da_en)
    `SDC_CHK("oe_b sel", 8'h81, oe_b)
    // Mid-scale preload first, so no settling wait is needed
    cmd(4'h1, 8'h80);
    cmd(4'h8, 8'hff);
    `SDC_CHK("codes", {8'hff, 48'h0, 8'h80}, codes)
  endtask
  // Short frame leaves its bits in the shifter for the next one
  task automatic t_partial;
    u_sdc_host_model.send({4'h2, 8'h00}, 4);
    repeat (10) @(negedge clk_i);
    `SDC_CHK("codes short", {8'hff, 48'h0, 8'h80}, codes)
    // Misaligned word f2 lands as a direction setting
    `SDC_CHK("oe_b short", 8'h8d, oe_b)
    u_sdc_host_model.send({8'h3c, 4'h0}, 8);
    repeat (10) @(negedge clk_i);
    `SDC_CHK("codes joined", {8'hff, 40'h0, 8'h3c, 8'h80}, codes)
    cmd(4'hf, 8'hff);
  endtask
  // Pins captured at the next select fall, shifted out after sck falls
  task automatic t_p2s;
    logic [11:0] got;
    got = 12'h000;
    cmd(4'he, 8'h00);
    fork
      u_sdc_host_model.send({4'ha, 8'h00}, 12);
      repeat (12) begin
        @(posedge sck);
        got = {got[10:0], sdo};
      end
    join
    repeat (10) @(negedge clk_i);
    `SDC_CHK("p2s out", 12'h05a, got)
  endtask
  task automatic t_ignored;
    cmd(4'ha, 8'hff);
    cmd(4'hb, 8'h00);
    `SDC_CHK("da_en ign", 8'h81, da_en)
    `SDC_CHK("codes ign", {8'hff, 40'h0, 8'h3c, 8'h80}, codes)
    cmd(4'hd, 8'ha5);
    `SDC_CHK("port out", 8'ha5, pins_out)
  endtask
  task automatic t_power_down;
    cmd(4'h0, 8'h00);
    `SDC_CHK("da_en pd", 8'h00, da_en)
    `SDC_CHK("oe_b pd", 8'h00, oe_b)
    `SDC_CHK("bias pd", 1'b0, bias)
  endtask
  task automatic t_ext_reset;
    cmd(4'h9, 8'h00);
    ext_rst_n = 1'b0;
    repeat (8) @(negedge clk_i);
    chk_idle();
    `SDC_CHK("codes rst", 64'h0, codes)
    ext_rst_n = 1'b1;
    repeat (4) @(negedge clk_i);
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    give_verdict();
  end
  initial begin
    rst_b_i = 1'b0;
    ext_rst_n = 1'b1;
    pins_in = 8'h5a;
    repeat (2) @(negedge clk_i);
    chk_idle();
    rst_b_i = 1'b1;
    repeat (4) @(negedge clk_i);
    t_setup();
    t_partial();
    t_ignored();
    t_p2s();
    t_power_down();
    t_ext_reset();
    give_verdict();
  end
endmodule
